// ===== core/tpw_defines.vh
`ifndef TPW_DEFINES_VH
`define TPW_DEFINES_VH
// Byte offsets on the APB bus
`define TPW_OFF_CTRL0    12'h000
`define TPW_OFF_CTRL1    12'h004
`define TPW_OFF_BUF0     12'h008
`define TPW_OFF_BUF1     12'h00c
`define TPW_OFF_DEAD     12'h010
`define TPW_OFF_PERIOD   12'h014
`define TPW_OFF_PH0      12'h018
`define TPW_OFF_PH1      12'h01c
`define TPW_OFF_PH2      12'h020
`define TPW_OFF_STAT     12'h024
`define TPW_OFF_IRQ_EN   12'h028
`define TPW_OFF_IRQ_CLR  12'h02c
// Control register 0 fields
`define TPW_C0_POL       0
`define TPW_C0_SPEC      1
`define TPW_C0_OUTEN     3
`define TPW_C0_LOWDIS    4
`define TPW_C0_MODE      6
// Control register 1 fields
`define TPW_C1_SECREG    1
// Buffer fields: pos in bits 0..2, neg in bits 4..6, one per phase
`define TPW_BUF_POS      0
`define TPW_BUF_NEG      4
// Status / interrupt bits
`define TPW_ST_PERIOD    0
`define TPW_ST_LOWDIS    1
// Reset values
`define TPW_RST_CTRL0    8'h00
`define TPW_RST_CTRL1    8'h00
`define TPW_RST_BUF      8'h00
`define TPW_RST_DEAD     8'h01
`define TPW_RST_TIMER    16'h0000
`define TPW_RST_STATE    6'h00
`endif

// ===== core/tpw_sync2.v
`timescale 1ns/1ps
// Two-flop synchroniser for a pin level
module tpw_sync2 (
  input  wire pclk,
  input  wire presetn,
  input  wire d,
  output reg  q
);
  reg meta_q;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q <= 1'b1;
      q      <= 1'b1;
    end
    else
    begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// ===== core/tpw_pwm.v
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "tpw_defines.vh"
module tpw_pwm (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        nmi_n,
  output reg  [2:0]  pos_out,
  output reg  [2:0]  neg_out,
  output reg         pins_en,
  output reg         irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  reg  [7:0]  ctrl0_q;
  reg  [7:0]  ctrl1_q;
  reg  [7:0]  buf0_q;
  reg  [7:0]  buf1_q;
  reg  [7:0]  dead_q;
  reg  [15:0] period_q;
  reg  [15:0] ph_rel_q [0:2];
  reg  [1:0]  stat_q;
  reg  [1:0]  irq_en_q;
  reg  [15:0] per_cnt_q;
  reg  [15:0] ph_cnt_q [0:2];
  reg  [2:0]  ph_run_q;
  reg  [7:0]  dt_cnt_q [0:2];
  reg  [1:0]  pos_sh_q [0:2];
  reg  [1:0]  neg_sh_q [0:2];
  reg  [2:0]  pos_lvl_q;
  reg  [2:0]  neg_lvl_q;
  reg         nmi_d_q;
  wire        nmi_s;
  wire        wr_en;
  wire        saw_mode;
  wire        per_zero;
  wire        nmi_fall;
  wire [2:0]  shift_ev;
  wire [2:0]  pair_low;
  wire        low_trip;
  wire [1:0]  ev_vec;
  reg  [31:0] rd_mux;
  reg         addr_ok;

  assign wr_en    = psel & penable & pwrite;
  assign saw_mode = ctrl0_q[`TPW_C0_MODE] & ~ctrl1_q[`TPW_C1_SECREG];
  assign per_zero = saw_mode & (per_cnt_q == 16'h0000);
  assign nmi_fall = nmi_d_q & ~nmi_s;
  assign pair_low = ~pos_lvl_q & ~neg_lvl_q;
  assign low_trip = ctrl0_q[`TPW_C0_LOWDIS] & (|pair_low);
  // Spec and polarity bits never gate the period interrupt in this mode
  assign ev_vec   = {low_trip, per_zero};

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser and edge detect
  tpw_sync2 u_nmi_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (nmi_n),
    .q       (nmi_s)
  );

  // Rests high like the idle pin, so leaving reset gives no false edge
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      nmi_d_q <= 1'b1;
    else
      nmi_d_q <= nmi_s;
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave
  // Zero wait states: pready answers every setup cycle one clock later
  always @*
  begin
    addr_ok = 1'b1;
    rd_mux  = 32'h0000_0000;
    case (paddr)
      `TPW_OFF_CTRL0:   rd_mux = {24'h000000, ctrl0_q};
      `TPW_OFF_CTRL1:   rd_mux = {24'h000000, ctrl1_q};
      `TPW_OFF_BUF0:    rd_mux = {24'h000000, buf0_q};
      `TPW_OFF_BUF1:    rd_mux = {24'h000000, buf1_q};
      `TPW_OFF_DEAD:    rd_mux = {24'h000000, dead_q};
      `TPW_OFF_PERIOD:  rd_mux = {16'h0000, period_q};
      `TPW_OFF_PH0:     rd_mux = {16'h0000, ph_rel_q[0]};
      `TPW_OFF_PH1:     rd_mux = {16'h0000, ph_rel_q[1]};
      `TPW_OFF_PH2:     rd_mux = {16'h0000, ph_rel_q[2]};
      `TPW_OFF_STAT:    rd_mux = {30'h0, stat_q};
      `TPW_OFF_IRQ_EN:  rd_mux = {30'h0, irq_en_q};
      `TPW_OFF_IRQ_CLR: rd_mux = 32'h0000_0000;
      default:          addr_ok = 1'b0;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~addr_ok;
      if (psel & ~penable & ~pwrite)
        prdata <= rd_mux;
    end
  end

  // Writes take effect at the access edge, where pready is already high
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl0_q     <= `TPW_RST_CTRL0;
      ctrl1_q     <= `TPW_RST_CTRL1;
      buf0_q      <= `TPW_RST_BUF;
      buf1_q      <= `TPW_RST_BUF;
      dead_q      <= `TPW_RST_DEAD;
      period_q    <= `TPW_RST_TIMER;
      ph_rel_q[0] <= `TPW_RST_TIMER;
      ph_rel_q[1] <= `TPW_RST_TIMER;
      ph_rel_q[2] <= `TPW_RST_TIMER;
      irq_en_q    <= 2'h0;
    end
    else
    begin
      if (wr_en & pready)
      begin
        case (paddr)
          `TPW_OFF_CTRL0:  ctrl0_q <= pwdata[7:0];
          `TPW_OFF_CTRL1:  ctrl1_q <= pwdata[7:0];
          `TPW_OFF_BUF0:   buf0_q <= pwdata[7:0];
          `TPW_OFF_BUF1:   buf1_q <= pwdata[7:0];
          // A zero dead time is refused, the one-shot needs at least one count
          `TPW_OFF_DEAD:   if (pwdata[7:0] != 8'h00) dead_q <= pwdata[7:0];
          `TPW_OFF_PERIOD: period_q <= pwdata[15:0];
          `TPW_OFF_PH0:    ph_rel_q[0] <= pwdata[15:0];
          `TPW_OFF_PH1:    ph_rel_q[1] <= pwdata[15:0];
          `TPW_OFF_PH2:    ph_rel_q[2] <= pwdata[15:0];
          `TPW_OFF_IRQ_EN: irq_en_q <= pwdata[1:0];
          default:         ctrl1_q <= ctrl1_q;
        endcase
      end
      if (nmi_fall | low_trip)
        ctrl0_q[`TPW_C0_OUTEN] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status, set wins over clear
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stat_q <= 2'h0;
    else if (wr_en & pready & (paddr == `TPW_OFF_IRQ_CLR))
      stat_q <= (stat_q & ~pwdata[1:0]) | ev_vec;
    else
      stat_q <= stat_q | ev_vec;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Period timer
  // Held at the reload value while the mode is off, so the first zero comes a full period after enabling
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      per_cnt_q <= `TPW_RST_TIMER;
    end
    else if (!saw_mode)
    begin
      per_cnt_q <= period_q;
    end
    else if (per_zero)
    begin
      per_cnt_q <= period_q;
    end
    else
      per_cnt_q <= per_cnt_q - 16'h0001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-phase one-shot, shift registers, dead time and output level
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : g_phase
      wire dt_busy;
      assign shift_ev[g] = ph_run_q[g] & (ph_cnt_q[g] == 16'h0001);
      assign dt_busy     = (dt_cnt_q[g] != 8'h00);

      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          ph_cnt_q[g] <= `TPW_RST_TIMER;
          ph_run_q[g] <= 1'b0;
          dt_cnt_q[g] <= 8'h00;
          pos_sh_q[g] <= 2'h3;
          neg_sh_q[g] <= 2'h3;
          pos_lvl_q[g] <= 1'b1;
          neg_lvl_q[g] <= 1'b1;
        end
        else
        begin
          if (per_zero)
          begin
            ph_cnt_q[g] <= ph_rel_q[g];
            ph_run_q[g] <= (ph_rel_q[g] != 16'h0000);
            // Bit 0 drives now, bit 1 after the shift
            pos_sh_q[g] <= {buf1_q[`TPW_BUF_POS + g], buf0_q[`TPW_BUF_POS + g]};
            neg_sh_q[g] <= {buf1_q[`TPW_BUF_NEG + g], buf0_q[`TPW_BUF_NEG + g]};
          end
          else if (ph_run_q[g])
          begin
            ph_cnt_q[g] <= ph_cnt_q[g] - 16'h0001;
            if (shift_ev[g])
            begin
              ph_run_q[g] <= 1'b0;
              // Bit 1 is copied down, so the level holds to the end of the period
              pos_sh_q[g] <= {pos_sh_q[g][1], pos_sh_q[g][1]};
              neg_sh_q[g] <= {neg_sh_q[g][1], neg_sh_q[g][1]};
            end
          end
          // A shift that meets a reload is dropped with the rest of the old period
          if (shift_ev[g] & ~per_zero)
            dt_cnt_q[g] <= dead_q;
          else if (dt_busy)
            dt_cnt_q[g] <= dt_cnt_q[g] - 8'h01;
          // Rising edges pass at once; falling edges after a shift wait out the dead time, at a reload they pass at once
          if (per_zero)
          begin
            pos_lvl_q[g] <= buf0_q[`TPW_BUF_POS + g];
            neg_lvl_q[g] <= buf0_q[`TPW_BUF_NEG + g];
          end
          else
          begin
            if (pos_sh_q[g][0] | (!dt_busy & !shift_ev[g]))
              pos_lvl_q[g] <= pos_sh_q[g][0];
            if (neg_sh_q[g][0] | (!dt_busy & !shift_ev[g]))
              neg_lvl_q[g] <= neg_sh_q[g][0];
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Pin outputs
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pos_out <= 3'h7;
      neg_out <= 3'h7;
      pins_en <= 1'b0;
      irq     <= 1'b0;
    end
    else
    begin
      pos_out <= pos_lvl_q;
      neg_out <= neg_lvl_q;
      // The pins drop in the same cycle that a both-low pair reaches the outputs
      pins_en <= ctrl0_q[`TPW_C0_OUTEN] & saw_mode & ~low_trip;
      // The interrupt runs one clock behind the status and enable registers
      irq     <= |(stat_q & irq_en_q);
    end
  end

endmodule

// ===== dv/tpw_pwm_props.sv
`timescale 1ns/1ps
`include "tpw_defines.vh"
module tpw_pwm_props (
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic        nmi_n,
  input logic [2:0]  pos_out,
  input logic [2:0]  neg_out,
  input logic        pins_en
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Shadow of the low-disable control bit, taken from completed writes
  logic lowdis_q;
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      lowdis_q <= 1'b0;
    else if (psel && penable && pready && pwrite && paddr == `TPW_OFF_CTRL0)
      lowdis_q <= pwdata[`TPW_C0_LOWDIS];
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_nmi_fall;
    $fell(nmi_n);
  endsequence
  AST_ZERO_WAIT: assert property (s_setup |=> pready) else $error("no ready after setup");
  AST_READY_PULSE: assert property (pready |-> $past(psel) && !$past(penable) ##1 !pready) else $error("bad ready");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready) else $error("error without ready");
  AST_ERR_READ_ZERO: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("error read data");
  AST_RESET_QUIET: assert property (!$past(presetn) |-> !pins_en && pos_out == 3'h7) else $error("reset levels");
  AST_NMI_RELEASE: assert property (s_nmi_fall |-> ##[1:6] !pins_en) else $error("pins kept after nmi");
  AST_LOW_TRIP: assert property (lowdis_q && $rose(|(~pos_out & ~neg_out)) |-> !pins_en) else $error("no trip");
  AST_FALL_HELD: assert property ($fell(pos_out[0]) |-> $past(pos_out[0], 2)) else $error("fall too early");
endmodule
bind tpw_pwm tpw_pwm_props i_tpw_pwm_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .nmi_n(nmi_n), .pos_out(pos_out),
  .neg_out(neg_out), .pins_en(pins_en));

// ===== dv/tpw_drive_model.sv
`timescale 1ns/1ps
module tpw_drive_model (
  input  logic       pclk,
  input  logic       presetn,
  input  logic [2:0] pos_out,
  input  logic [2:0] neg_out,
  input  logic       pins_en,
  output int         shoot_cnt
);
  logic [2:0] gate_p;
  logic [2:0] gate_n;
  // Released pins fall to the pull-ups, which keep the switches off
  assign gate_p = pins_en ? pos_out : 3'h7;
  assign gate_n = pins_en ? neg_out : 3'h7;
  // Both gates of a leg low together is a shoot-through
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      shoot_cnt <= 0;
    else if ((~gate_p & ~gate_n) != 3'h0)
      shoot_cnt <= shoot_cnt + 1;
  end
endmodule

// ===== dv/tpw_pwm_tb_top.sv
`timescale 1ns/1ps
`include "tpw_defines.vh"
module tpw_pwm_tb_top;
  typedef struct {logic [11:0] a; logic w; logic [31:0] d; logic [31:0] e; logic r;} tpw_row_t;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        nmi_n = 1'b1;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, pins_en, irq, er;
  logic [2:0]  pos_out, neg_out;
  int          failures, cmp_count, cyc, shoot_cnt;
  int          lo_p [0:2];
  int          lo_n [0:2];
  int          ph [0:2] = '{5, 8, 11};
  tpw_row_t    rows [0:17];
  tpw_pwm i_tpw_pwm (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .nmi_n(nmi_n),
    .pos_out(pos_out), .neg_out(neg_out), .pins_en(pins_en), .irq(irq));
  tpw_drive_model i_tpw_drive_model (.pclk(pclk), .presetn(presetn), .pos_out(pos_out), .neg_out(neg_out),
    .pins_en(pins_en), .shoot_cnt(shoot_cnt));
  ////////////////////////////////////////////////////////////////////////////
  always #2.5 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      print_verdict();
    end
  end
  task print_verdict;
    if (failures == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(n, 1, "ready latency");
  endtask
  // Low-level cycles of every pin over two carrier periods
  task measure;
    lo_p = '{0, 0, 0};
    lo_n = '{0, 0, 0};
    repeat (40)
    begin
      @(posedge pclk);
      for (int i = 0; i < 3; i++)
      begin
        lo_p[i] += !pos_out[i];
        lo_n[i] += !neg_out[i];
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rows = '{'{`TPW_OFF_CTRL0, 0, 0, 0, 0}, '{`TPW_OFF_DEAD, 0, 0, 1, 0}, '{`TPW_OFF_PERIOD, 0, 0, 0, 0},
      '{`TPW_OFF_STAT, 0, 0, 0, 0}, '{12'h030, 0, 0, 0, 1}, '{12'h030, 1, 5, 0, 1}, '{`TPW_OFF_DEAD, 1, 0, 0, 0},
      '{`TPW_OFF_DEAD, 0, 0, 1, 0}, '{`TPW_OFF_BUF0, 1, 'h47, 0, 0}, '{`TPW_OFF_BUF1, 1, 'h70, 0, 0},
      '{`TPW_OFF_DEAD, 1, 3, 0, 0}, '{`TPW_OFF_PERIOD, 1, 19, 0, 0}, '{`TPW_OFF_PH0, 1, 5, 0, 0},
      '{`TPW_OFF_PH1, 1, 8, 0, 0}, '{`TPW_OFF_PH2, 1, 11, 0, 0}, '{`TPW_OFF_IRQ_EN, 1, 1, 0, 0},
      '{`TPW_OFF_CTRL1, 1, 0, 0, 0}, '{`TPW_OFF_CTRL0, 1, 'h4b, 0, 0}};
    repeat (3) @(posedge pclk);
    chk({pins_en, pos_out, neg_out}, 32'h3f, "reset levels");
    presetn <= 1'b1;
    foreach (rows[i])
    begin
      apb(rows[i].a, rows[i].w, rows[i].d);
      if (!rows[i].w)
        chk(rd, rows[i].e, "read value");
      chk({31'h0, er}, {31'h0, rows[i].r}, "error flag");
    end
    repeat (60) @(posedge pclk);
    measure();
    for (int i = 0; i < 3; i++)
    begin
      chk(lo_p[i], 2 * (20 - ph[i] - 4), "pos low width");
      chk(lo_n[i], (i == 2) ? 0 : 2 * (ph[i] + 1), "neg low width");
    end
    chk(shoot_cnt, 0, "overlap of lows");
    chk({31'h0, irq}, 32'h1, "irq not raised");
    apb(`TPW_OFF_STAT, 0, 0);
    chk(rd & 32'h1, 32'h1, "period status");
    apb(`TPW_OFF_IRQ_EN, 1, 0);
    apb(`TPW_OFF_IRQ_CLR, 1, 3);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0, "irq not masked");
    nmi_n <= 1'b0;
    repeat (8) @(posedge pclk);
    chk({31'h0, pins_en}, 32'h0, "nmi release");
    nmi_n <= 1'b1;
    apb(`TPW_OFF_CTRL0, 0, 0);
    chk(rd, 32'h43, "output bit kept");
    apb(`TPW_OFF_CTRL0, 1, 'h5b);
    apb(`TPW_OFF_BUF0, 1, 'h46);
    repeat (50) @(posedge pclk);
    chk({31'h0, pins_en}, 32'h0, "no low trip");
    apb(`TPW_OFF_CTRL0, 0, 0);
    chk(rd, 32'h53, "trip bit");
    apb(`TPW_OFF_STAT, 0, 0);
    chk(rd & 32'h2, 32'h2, "trip status");
    presetn <= 1'b0;
    @(posedge pclk);
    chk({pins_en, pos_out, neg_out}, 32'h3f, "mid-run reset levels");
    presetn <= 1'b1;
    apb(`TPW_OFF_CTRL0, 0, 0);
    chk(rd, 32'h0, "control after reset");
    print_verdict();
  end
endmodule
